/* logic/rss_pkg.sv */
/*
  Constants for the rotate / fill / sleep execution block.
  Assumes a single 125 MHz clock and an AXI4-Lite master for the registers.
*/
// Overview of operation
// - Rotate-right-no-carry shifts the file value right one place, bit 0 going to bit 7.
// - That rotate updates only negative and zero, from the rotated result.
// - Destination 0 writes the result to the working register, 1 back to the file.
// - Access 0 maps the address into the access bank, access 1 uses the bank select.
// - Access 0 with extended set on and address at most 95 uses indexed literal offset.
// - The fill instruction writes all ones to the file and touches no status flag.
// - For the fill, access 1 lets the bank select pick the bank, 0 the access bank.
// - Sleep is the fixed code 0000 0000 0000 0011 with no operands.
// - Sleep clears the active-low power-down flag.
// - Sleep sets the active-low timeout flag.
// - Sleep clears the watchdog counter and its postscaler.
// - Sleep halts the oscillator in the last phase of its cycle.
// - A watchdog wake-up clears the timeout flag; other wake-ups leave it set.
package rss_pkg;
  localparam logic [7:0] ROT_OPC = 8'h0040 >> 2;
  localparam logic [5:0] ROT_OP6 = 6'h10;
  localparam logic [6:0] FILL_OP7 = 7'h34;
  localparam logic [15:0] SLEEP_CODE = 16'h0003;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  // Register byte addresses
  localparam logic [7:0] A_INSN = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_FILE = 8'h0C;
  localparam logic [7:0] A_RESULT = 8'h10;
  localparam logic [7:0] A_WAKE = 8'h14;
  // INSN write bit 0 (C_FIN), then CTRL fields
  localparam int C_FIN = 0;
  localparam int C_W = 8;
  localparam int C_BSR = 16;
  localparam int C_EXT = 20;
  localparam int C_FSR = 24;
  // STATUS fields
  localparam int S_N = 0;
  localparam int S_Z = 1;
  localparam int S_PD = 2;
  localparam int S_TO = 3;
  localparam int S_SLP = 4;
  localparam int S_BUSY = 5;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {PH_IDLE, PH_DEC, PH_READ, PH_PROC, PH_WB} rss_phase_t;
  typedef enum logic [1:0] {K_NONE, K_ROT, K_FILL, K_SLEEP} rss_kind_t;
endpackage

/* logic/rss_exec.sv */
/*
  Execution of rotate-right-no-carry, fill-ones and sleep, with AXI4-Lite registers.
  Assumes a single clock; the file register array stands in for data memory.
*/
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module rss_exec
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power state
  output logic osc_halted,
  output logic wdt_clear_pulse
);
  logic [7:0] fmem [0:4095];
  logic [15:0] insn_q;
  logic [7:0] w_q, bsr_q, fsr_q, res_q, opnd_q;
  logic ext_q, n_q, z_q, pd_n_q, to_n_q, slp_q, wdt_clr_q;
  logic [11:0] addr_q;
  rss_phase_t ph_q;
  rss_kind_t kind_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic awready_q, wready_q, arready_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                           input logic [3:0] bank_select_reg, input logic ext,
                                           input logic [7:0] fsr);
    if (!a && ext && f <= IDX_LIMIT)
      eff_addr = {4'h0, fsr + f};
    else if (!a)
      eff_addr = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI_BANK, f};
    else
      eff_addr = {bank_select_reg, f};
  endfunction

  // Decode
  wire is_rot = insn_q[15:10] == ROT_OP6;
  wire is_fill = insn_q[15:9] == FILL_OP7;
  wire is_sleep = insn_q == SLEEP_CODE;
  wire [7:0] rot_res = {opnd_q[0], opnd_q[7:1]};
  wire dest_f = insn_q[9];
  wire acc_bit = is_rot ? insn_q[8] : insn_q[8];
  wire [11:0] ea = eff_addr(insn_q[7:0], acc_bit, bsr_q[3:0], ext_q, fsr_q);

  function automatic logic araddr_in_map(input logic [7:0] a);
    araddr_in_map = a == A_INSN || a == A_CTRL || a == A_STATUS || a == A_FILE ||
                    a == A_RESULT || a == A_WAKE;
  endfunction

  // Register bus
  wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  wire rd_go = s_axi_arvalid && arready_q;
  // An instruction write while idle and awake aims FILE accesses; only bit 0 clear starts it
  wire insn_wr = wr_go && awaddr_q == A_INSN;
  wire start = insn_wr && wstrb_q[0] && wdata_q[C_FIN] == 1'b0;
  wire wake = wr_go && awaddr_q == A_WAKE && wstrb_q[0] && slp_q;
  wire busy = ph_q != PH_IDLE;
  // Working register is frozen while an instruction may write it
  wire w_wr = wr_go && awaddr_q == A_CTRL && wstrb_q[1] && !busy;
  wire [31:0] status_w = {26'h0, busy, slp_q, to_n_q, pd_n_q, z_q, n_q};
  wire [31:0] ctrl_w = {fsr_q, 3'h0, ext_q, bsr_q[3:0], w_q, 8'h00};
  wire rd_hit = araddr_in_map(s_axi_araddr);
  wire wr_hit = araddr_in_map(awaddr_q);

  logic [31:0] rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      A_INSN: rd_mux = {16'h0, insn_q};
      A_CTRL: rd_mux = ctrl_w;
      A_STATUS: rd_mux = status_w;
      A_FILE: rd_mux = {24'h0, fmem[ea]};
      A_RESULT: rd_mux = {24'h0, res_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Write channels; readies are registered inverses of the hold flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OK : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read channel; one read in flight, so arready drops while data waits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OK;
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OK : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Config registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bsr_q <= 8'h00;
      ext_q <= 1'b0;
      fsr_q <= 8'h00;
    end
    else if (wr_go && awaddr_q == A_CTRL)
    begin
      if (wstrb_q[2])
      begin
        bsr_q <= {4'h0, wdata_q[C_BSR +: 4]};
        ext_q <= wdata_q[C_EXT];
      end
      if (wstrb_q[3])
        fsr_q <= wdata_q[C_FSR +: 8];
    end
  end

  // Four-phase sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph_q <= PH_IDLE;
      kind_q <= K_NONE;
      insn_q <= 16'h0000;
    end
    else
    begin
      case (ph_q)
        PH_IDLE:
          if (insn_wr && !slp_q)
          begin
            insn_q <= wdata_q[31:16];
            if (start)
              ph_q <= PH_DEC;
          end
        PH_DEC:
        begin
          kind_q <= is_sleep ? K_SLEEP : is_rot ? K_ROT : is_fill ? K_FILL : K_NONE;
          ph_q <= PH_READ;
        end
        PH_READ: ph_q <= PH_PROC;
        PH_PROC: ph_q <= PH_WB;
        PH_WB: ph_q <= PH_IDLE;
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

  // Working register and rotate flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_q <= 8'h00;
      n_q <= 1'b0;
      z_q <= 1'b0;
    end
    else if (ph_q == PH_WB && kind_q == K_ROT)
    begin
      n_q <= rot_res[7];
      z_q <= rot_res == 8'h00;
      if (!dest_f)
        w_q <= rot_res;
    end
    else if (w_wr)
      w_q <= wdata_q[C_W +: 8];
  end

  // Operand fetch and result
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      addr_q <= 12'h000;
    end
    else if (ph_q == PH_READ)
    begin
      addr_q <= ea;
      opnd_q <= fmem[ea];
    end
    else if (ph_q == PH_PROC && kind_q == K_ROT)
      res_q <= rot_res;
    else if (ph_q == PH_PROC && kind_q == K_FILL)
      res_q <= ALL_ONES;
  end

  // Power state; wake cannot meet sleep entry, since start is refused asleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pd_n_q <= 1'b1;
      to_n_q <= 1'b1;
      slp_q <= 1'b0;
      wdt_clr_q <= 1'b0;
    end
    else
    begin
      wdt_clr_q <= 1'b0;
      if (ph_q == PH_PROC && kind_q == K_SLEEP)
      begin
        pd_n_q <= 1'b0;
        to_n_q <= 1'b1;
        // Watchdog lives outside; it clears counter and postscaler on this pulse
        wdt_clr_q <= 1'b1;
      end
      if (ph_q == PH_WB && kind_q == K_SLEEP)
        slp_q <= 1'b1;
      if (wake)
      begin
        slp_q <= 1'b0;
        if (wdata_q[0])
          to_n_q <= 1'b0;
      end
    end
  end

  // File memory write-back
  always_ff @(posedge aclk)
  begin
    if (ph_q == PH_WB && kind_q == K_ROT && dest_f)
      fmem[addr_q] <= rot_res;
    else if (ph_q == PH_WB && kind_q == K_FILL)
      fmem[addr_q] <= ALL_ONES;
    else if (wr_go && awaddr_q == A_FILE && wstrb_q[0] && !busy)
      fmem[ea] <= wdata_q[7:0];
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign osc_halted = slp_q;
  assign wdt_clear_pulse = wdt_clr_q;
endmodule
`default_nettype wire

/* testbench/rss_exec_chk.sv */
/*
  Port checker for rss_exec: bus handshakes and sleep signals.
  Bound to every rss_exec instance; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module rss_exec_chk
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power state
  input wire logic osc_halted,
  input wire logic wdt_clear_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped early");
  property p_rh;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rh: assert property (p_rh) else $error("read data not held");
  property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("arready with read pending");
  property p_wp; wdt_clear_pulse |=> !wdt_clear_pulse; endproperty
  a_wp: assert property (p_wp) else $error("watchdog clear too long");
  property p_wo; wdt_clear_pulse |=> osc_halted; endproperty
  a_wo: assert property (p_wo) else $error("no halt after clear");
  property p_or; $rose(osc_halted) |-> $past(wdt_clear_pulse); endproperty
  a_or: assert property (p_or) else $error("halt without clear");
  property p_sl; osc_halted |-> !wdt_clear_pulse; endproperty
  a_sl: assert property (p_sl) else $error("clear while halted");
  // Reset itself is the cause here, so this one is never disabled
  property p_rst;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !osc_halted && !wdt_clear_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  c_sleep: cover property (wdt_clear_pulse);
  c_wake: cover property ($fell(osc_halted));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind rss_exec rss_exec_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .osc_halted(osc_halted), .wdt_clear_pulse(wdt_clear_pulse));
`default_nettype wire

/* testbench/rss_tb.sv */
/*
  Self-checking bench for rss_exec, driven over its register bus.
  Assumes the port checker is bound from its own file.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rss_pkg::*;
  logic aclk, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic osc_halted, wdt_clear_pulse;
  int num_errors, samples_checked, pulses;
  rss_exec dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_halted(osc_halted),
    .wdt_clear_pulse(wdt_clear_pulse));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (wdt_clear_pulse === 1'b1) pulses++;
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Spare edge so the next call never reassigns in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    r = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic ex(input logic [15:0] i);
    int n;
    n = 0;
    wr(A_INSN, {i, 16'h0000});
    do
    begin
      rd(A_STATUS);
      n++;
    end while (r[S_BUSY] !== 1'b0 && n < 20);
    chk({7'h00, r[S_BUSY]}, 8'h00);
  endtask
  // Operand load without start, then file byte
  task automatic put(input logic [15:0] i, input logic [7:0] v);
    wr(A_INSN, {i, 16'h0001});
    wr(A_FILE, {24'h00_0000, v});
  endtask
  task automatic t_rot;
    wr(A_CTRL, 32'h0002_0000);
    put(16'h4320, 8'hD7);
    ex(16'h4320);
    rd(A_FILE);
    chk(r[7:0], 8'hEB);
    rd(A_STATUS);
    chk(r[7:0] & 8'h03, 8'h01);
    put(16'h4120, 8'h01);
    ex(16'h4120);
    rd(A_FILE);
    chk(r[7:0], 8'h01);
    rd(A_CTRL);
    chk(r[15:8], 8'h80);
    put(16'h4320, 8'h00);
    ex(16'h4320);
    rd(A_STATUS);
    chk(r[7:0] & 8'h03, 8'h02);
  endtask
  task automatic t_fill;
    put(16'h6920, 8'h5A);
    ex(16'h6920);
    rd(A_FILE);
    chk(r[7:0], 8'hFF);
    rd(A_STATUS);
    chk(r[7:0] & 8'h03, 8'h02);
    rd(A_RESULT);
    chk(r[7:0], ALL_ONES);
  endtask
  task automatic t_bank;
    put(16'h6870, 8'h11);
    wr(A_CTRL, 32'h000F_0000);
    wr(A_INSN, {16'h6970, 16'h0001});
    rd(A_FILE);
    chk(r[7:0], 8'h11);
    wr(A_CTRL, 32'h3010_0000);
    put(16'h6810, 8'h33);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_INSN, {16'h6940, 16'h0001});
    rd(A_FILE);
    chk(r[7:0], 8'h33);
  endtask
  task automatic t_sleep;
    for (int k = 0; k < 2; k++)
    begin
      ex(SLEEP_CODE);
      rd(A_STATUS);
      chk(r[7:0] & 8'h1C, 8'h18);
      chk({7'h00, osc_halted}, 8'h01);
      chk(pulses[7:0], 8'(k + 1));
      wr(A_WAKE, {31'h0000_0000, k == 0});
      chk({6'h00, resp}, {6'h00, RESP_OK});
      rd(A_STATUS);
      chk(r[7:0] & 8'h18, k ? 8'h08 : 8'h00);
    end
  endtask
  task automatic t_err;
    rd(8'h20);
    chk({6'h00, resp}, {6'h00, RESP_SLVERR});
    chk(r[7:0], 8'h00);
    wr(8'h20, 32'h0000_0000);
    chk({6'h00, resp}, {6'h00, RESP_SLVERR});
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_rot;
    t_fill;
    t_bank;
    t_sleep;
    t_err;
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
